// >>> include/wake_cfg_pkg.sv
/*
 Package of constants for the standby wake source configuration block.
 It assumes one 10 MHz core clock and an AXI4-Lite register bus.
*/
package wake_cfg_pkg;
   localparam int          NUM_SRC       = 4;
   localparam int          SRC_STRIDE    = 8;
   localparam int          SEL_LSB       = 4;
   localparam int          STAT_LSB      = 2;
   localparam int          EN_BIT        = 0;
   localparam int          ADDR_W        = 4;
   localparam logic [3:0]  OFF_MODE_CTRL = 4'h0;
   localparam logic [3:0]  OFF_REQ_CLEAR = 4'h4;
   localparam logic [3:0]  OFF_INT_STAT  = 4'h8;
   localparam logic [3:0]  OFF_INT_MASK  = 4'hc;
   localparam logic [2:0]  TRIG_LOW      = 3'h0;
   localparam logic [2:0]  TRIG_HIGH     = 3'h1;
   localparam logic [2:0]  TRIG_FALL     = 3'h2;
   localparam logic [2:0]  TRIG_RISE     = 3'h3;
   localparam logic [2:0]  TRIG_BOTH     = 3'h4;
   localparam logic [2:0]  TRIG_RESET    = 3'h2;
   localparam logic [1:0]  EDGE_NONE     = 2'h0;
   localparam logic [4:0]  CLR_RTC       = 5'h08;
   localparam logic [4:0]  CLR_EXT_SIX   = 5'h09;
   localparam logic [4:0]  CLR_EXT_SEVEN = 5'h0a;
   localparam logic [4:0]  CLR_RC1       = 5'h0b;
   localparam logic [4:0]  CLR_PROHIB    = 5'h0d;
   localparam logic [31:0] CTRL_RESET    = 32'h2020_2020;
   localparam logic [31:0] CTRL_RSVD     = 32'h8282_8282;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   typedef enum logic [1:0] {
      WR_COLLECT = 2'b00,
      WR_RESP    = 2'b01
   } wr_state_t;
endpackage

// >>> logic/wake_edge_detect.sv
/*
 Level and edge detector for one wake source.
 It assumes the source line is already synchronous to core_clk.
*/
`timescale 1ns/1ps
module wake_edge_detect (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       level,
   input  wire logic [2:0] triggerSelect,
   output logic            hit,
   output logic            rose,
   output logic            fell
);
   import wake_cfg_pkg::*;

   logic prevLevel;

   // Reset loads the present level so that a line already high is not seen as a rise.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         prevLevel <= level;
      end else begin
         prevLevel <= level;
      end
   end

   assign rose = level & ~prevLevel;
   assign fell = ~level & prevLevel;

   always_comb begin
      case (triggerSelect)
         TRIG_LOW:  hit = ~level;
         TRIG_HIGH: hit = level;
         TRIG_FALL: hit = fell;
         TRIG_RISE: hit = rose;
         TRIG_BOTH: hit = rose | fell;
         default:   hit = 1'b0;
      endcase
   end
endmodule

// >>> logic/standby_wake_source_config.sv
/*
 Wake source configuration, edge status and request clearing for four
 standby wake sources, with an AXI4-Lite register slave and one interrupt.
 It assumes all inputs are synchronous to core_clk and that the standby
 controller outside samples standbyClearReq.
*/
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
module standby_wake_source_config (
   input  wire logic                             core_clk,
   input  wire logic                             sys_rst,
   input  wire logic                             remoteRxOneRequest,
   input  wire logic                             externalInputSeven,
   input  wire logic                             externalInputSix,
   input  wire logic                             rtcRequest,
   input  wire logic                             standbyActive,
   output logic                                  standbyClearReq,
   output logic                                  irq,
   input  wire logic [wake_cfg_pkg::ADDR_W-1:0]  awaddr,
   input  wire logic                             awvalid,
   output logic                                  awready,
   input  wire logic [31:0]                      wdata,
   input  wire logic [3:0]                       wstrb,
   input  wire logic                             wvalid,
   output logic                                  wready,
   output logic [1:0]                            bresp,
   output logic                                  bvalid,
   input  wire logic                             bready,
   input  wire logic [wake_cfg_pkg::ADDR_W-1:0]  araddr,
   input  wire logic                             arvalid,
   output logic                                  arready,
   output logic [31:0]                           rdata,
   output logic [1:0]                            rresp,
   output logic                                  rvalid,
   input  wire logic                             rready
);
   import wake_cfg_pkg::*;

   wr_state_t             wrState;
   logic [ADDR_W-1:0]     awAddr;
   logic [31:0]           wData;
   logic [3:0]            wStrb;
   logic                  wrFire;
   logic [2:0]            triggerSelect [NUM_SRC];
   logic [1:0]            edgeStatus    [NUM_SRC];
   logic [NUM_SRC-1:0]    wakeEnable;
   logic [NUM_SRC-1:0]    pending;
   logic [NUM_SRC-1:0]    intMask;
   logic [NUM_SRC-1:0]    srcLevel;
   logic [NUM_SRC-1:0]    hit;
   logic [NUM_SRC-1:0]    rose;
   logic [NUM_SRC-1:0]    fell;
   logic [NUM_SRC-1:0]    wakeEvent;
   logic [NUM_SRC-1:0]    clrHit;
   logic [NUM_SRC-1:0]    w1cHit;
   logic [31:0]           ctrlImage;

   function automatic logic [3:0] wordOf(input logic [ADDR_W-1:0] a);
      wordOf = {a[3:2], 2'b00};
   endfunction

   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      isMapped = (wordOf(a) == OFF_MODE_CTRL) || (wordOf(a) == OFF_REQ_CLEAR) ||
                 (wordOf(a) == OFF_INT_STAT) || (wordOf(a) == OFF_INT_MASK);
   endfunction

   function automatic logic [NUM_SRC-1:0] clearMask(input logic [4:0] code);
      case (code)
         CLR_RTC:       clearMask = 4'h1;
         CLR_EXT_SIX:   clearMask = 4'h2;
         CLR_EXT_SEVEN: clearMask = 4'h4;
         CLR_RC1:       clearMask = 4'h8;
         default:       clearMask = 4'h0;
      endcase
   endfunction

   // Index 0 is the clock source at the lowest byte, index 3 receiver one at the top.
   assign srcLevel = {remoteRxOneRequest, externalInputSeven, externalInputSix, rtcRequest};

   for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      wake_edge_detect u_detect (
         .core_clk      (core_clk),
         .sys_rst       (sys_rst),
         .level         (srcLevel[i]),
         .triggerSelect (triggerSelect[i]),
         .hit           (hit[i]),
         .rose          (rose[i]),
         .fell          (fell[i])
      );
   end

   // A source that is disabled never produces an event.
   assign wakeEvent = hit & wakeEnable;

   // The write lands when both address and data are held and no response is pending.
   assign wrFire = (wrState == WR_COLLECT) && !awready && !wready;

   // Prohibited and foreign codes select nothing and so change nothing.
   assign clrHit = (wrFire && wordOf(awAddr) == OFF_REQ_CLEAR && wStrb[0]) ?
                   clearMask(wData[4:0]) : '0;
   assign w1cHit = (wrFire && wordOf(awAddr) == OFF_INT_STAT && wStrb[0]) ?
                   wData[NUM_SRC-1:0] : '0;

   always_comb begin
      ctrlImage = '0;
      for (int i = 0; i < NUM_SRC; i++) begin
         ctrlImage[i*SRC_STRIDE+SEL_LSB +: 3] = triggerSelect[i];
         if (triggerSelect[i] == TRIG_BOTH) begin
            ctrlImage[i*SRC_STRIDE+STAT_LSB +: 2] = edgeStatus[i];
         end
         ctrlImage[i*SRC_STRIDE+EN_BIT] = wakeEnable[i];
      end
   end

   // Write channel.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wrState <= WR_COLLECT;
         awready <= 1'b1;
         wready  <= 1'b1;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
         awAddr  <= '0;
         wData   <= '0;
         wStrb   <= '0;
      end else begin
         case (wrState)
            WR_COLLECT: begin
               if (awvalid && awready) begin
                  awready <= 1'b0;
                  awAddr  <= awaddr;
               end
               if (wvalid && wready) begin
                  wready <= 1'b0;
                  wData  <= wdata;
                  wStrb  <= wstrb;
               end
               if (wrFire) begin
                  wrState <= WR_RESP;
                  bvalid  <= 1'b1;
                  bresp   <= isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
               end
            end
            WR_RESP: begin
               if (bready) begin
                  wrState <= WR_COLLECT;
                  bvalid  <= 1'b0;
                  awready <= 1'b1;
                  wready  <= 1'b1;
               end
            end
            default: begin
               wrState <= WR_COLLECT;
            end
         endcase
      end
   end

   // Mode control fields; each source owns one byte lane.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_SRC; i++) begin
            triggerSelect[i] <= TRIG_RESET;
         end
         wakeEnable <= '0;
      end else if (wrFire && wordOf(awAddr) == OFF_MODE_CTRL) begin
         for (int i = 0; i < NUM_SRC; i++) begin
            if (wStrb[i]) begin
               // The receiver and clock fields hold only rising and falling edge in use.
               triggerSelect[i] <= wData[i*SRC_STRIDE+SEL_LSB +: 3];
               // Enable is taken as written; a field change in the same write is unsafe.
               wakeEnable[i]    <= wData[i*SRC_STRIDE+EN_BIT];
            end
         end
      end
   end

   // Edge status: a fresh edge wins over a clear in the same cycle.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_SRC; i++) begin
            edgeStatus[i] <= EDGE_NONE;
         end
      end else begin
         for (int i = 0; i < NUM_SRC; i++) begin
            if (wakeEvent[i] && triggerSelect[i] == TRIG_BOTH) begin
               edgeStatus[i] <= (clrHit[i] ? EDGE_NONE : edgeStatus[i]) |
                                {fell[i], rose[i]};
            end else if (clrHit[i]) begin
               edgeStatus[i] <= EDGE_NONE;
            end
         end
      end
   end

   // Pending requests double as sticky interrupt status.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pending <= '0;
      end else begin
         pending <= (pending & ~(clrHit | w1cHit)) | wakeEvent;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         intMask <= '0;
      end else if (wrFire && wordOf(awAddr) == OFF_INT_MASK && wStrb[0]) begin
         intMask <= wData[NUM_SRC-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(pending & intMask);
      end
   end

   // The request is held only in standby; out of standby the event still sets pending.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         standbyClearReq <= 1'b0;
      end else begin
         standbyClearReq <= standbyActive && |wakeEvent;
      end
   end

   // Read channel.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else if (rvalid) begin
         if (rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         case (wordOf(araddr))
            OFF_MODE_CTRL: rdata <= ctrlImage & ~CTRL_RSVD;
            OFF_INT_STAT:  rdata <= {{(32-NUM_SRC){1'b0}}, pending};
            OFF_INT_MASK:  rdata <= {{(32-NUM_SRC){1'b0}}, intMask};
            default:       rdata <= '0;
         endcase
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   sequence sWriteLands;
      wrFire;
   endsequence

   sequence sRespHeld;
      bvalid [*1] ##1 (bvalid || $past(bready));
   endsequence

   property pWriteAnswered;
      sWriteLands |=> sRespHeld;
   endproperty

   AST_WRITE_ANSWERED: assert property (pWriteAnswered)
      else $error("write response did not follow the write");

   AST_RESET_STATE: assert property (@(posedge core_clk) disable iff (1'b0)
      sys_rst |=> (ctrlImage == CTRL_RESET) && (pending == '0) && !irq)
      else $error("control image not at reset value after reset");

   AST_RESERVED_ZERO: assert property (
      rvalid && $past(wordOf(araddr) == OFF_MODE_CTRL && arvalid && arready)
      |-> (rdata & CTRL_RSVD) == '0)
      else $error("reserved control bits did not read zero");

   AST_STANDBY_REQ: assert property (
      standbyClearReq |-> $past(standbyActive) && $past(|(hit & wakeEnable)))
      else $error("wake request without an enabled event in standby");

   AST_PROHIB_CODE: assert property (
      wrFire && wordOf(awAddr) == OFF_REQ_CLEAR && wData[4:0] >= CLR_PROHIB
      && wakeEvent == '0 |=> pending == $past(pending))
      else $error("prohibited clear code changed pending requests");

   AST_IRQ_LEVEL: assert property (
      |(pending & intMask) |=> irq)
      else $error("unmasked pending request did not raise the interrupt");

   AST_OUT_OF_STANDBY: assert property (
      !standbyActive |=> !standbyClearReq)
      else $error("wake request raised outside standby");

   AST_READ_ANSWERED: assert property (
      arvalid && arready |=> rvalid && !arready)
      else $error("read address taken without a read answer");

   AST_REQ_RESET: assert property (@(posedge core_clk) disable iff (1'b0)
      sys_rst |=> !standbyClearReq && !bvalid && !rvalid)
      else $error("request or bus answer active after reset");

   for (genvar i = 0; i < NUM_SRC; i++) begin : g_chk
      AST_EDGE_RISE: assert property (
         wakeEvent[i] && triggerSelect[i] == TRIG_BOTH && rose[i]
         |=> edgeStatus[i][0])
         else $error("rising edge not recorded in edge status");

      AST_EDGE_FALL: assert property (
         wakeEvent[i] && triggerSelect[i] == TRIG_BOTH && fell[i]
         |=> edgeStatus[i][1])
         else $error("falling edge not recorded in edge status");

      AST_EDGE_CLEAR: assert property (
         clrHit[i] && !wakeEvent[i] |=> edgeStatus[i] == EDGE_NONE)
         else $error("clear did not zero the edge status");

      AST_CLEAR_PENDING: assert property (
         clrHit[i] && !wakeEvent[i] |=> !pending[i])
         else $error("clear code did not drop the pending request");

      AST_EDGE_HOLD: assert property (
         !wakeEvent[i] && !clrHit[i] |=> $stable(edgeStatus[i]))
         else $error("edge status changed without an event or a clear");

      AST_STATUS_GATED: assert property (
         triggerSelect[i] != TRIG_BOTH |-> ctrlImage[i*SRC_STRIDE+STAT_LSB +: 2] == 2'h0)
         else $error("edge status visible outside both-edge mode");

      AST_PROHIB_SEL: assert property (
         triggerSelect[i] > TRIG_BOTH |-> !hit[i])
         else $error("prohibited trigger code produced a hit");

      AST_DISABLED_QUIET: assert property (
         $rose(pending[i]) |-> $past(wakeEnable[i]))
         else $error("disabled source set a pending request");
   end
endmodule

// >>> test/standby_wake_source_config_tb.sv
/*
 Self-checking bench for the standby wake source configuration block.
 It assumes the package register map; the bench drives every port itself.
*/
`timescale 1ns/1ps
module standby_wake_source_config_tb;
   import wake_cfg_pkg::*;
   logic        core_clk      = 1'b0;
   logic        sys_rst       = 1'b1;
   logic [3:0]  srcLine       = 4'h0;
   logic        standbyActive = 1'b0;
   logic        standbyClearReq;
   logic        irq;
   logic [3:0]  awaddr        = 4'h0;
   logic        awvalid       = 1'b0;
   logic        awready;
   logic [31:0] wdata         = 32'h0;
   logic [3:0]  wstrb         = 4'h0;
   logic        wvalid        = 1'b0;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic [3:0]  araddr        = 4'h0;
   logic        arvalid       = 1'b0;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   int          errorCnt      = 0;
   int          comparisons   = 0;
   int          reqSeen       = 0;

   standby_wake_source_config i_standby_wake_source_config (
      .core_clk(core_clk), .sys_rst(sys_rst), .remoteRxOneRequest(srcLine[3]),
      .externalInputSeven(srcLine[2]), .externalInputSix(srcLine[1]),
      .rtcRequest(srcLine[0]), .standbyActive(standbyActive),
      .standbyClearReq(standbyClearReq), .irq(irq), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1)
   );

   always #50 core_clk = ~core_clk;

   // Wake requests last one cycle for edge codes but as long as the level for level codes, so they are counted on every edge.
   always @(posedge core_clk) begin
      if (standbyClearReq === 1'b1) reqSeen <= reqSeen + 1;
   end

   task automatic stopTest();
      $display("comparisons %0d errors %0d", comparisons, errorCnt);
      if (errorCnt == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
         errorCnt++;
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      bit awOk;
      bit wOk;
      bit done;
      awOk = 0;
      wOk = 0;
      done = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (int n = 0; n < 50 && !done; n++) begin
         @(posedge core_clk);
         if (bvalid === 1'b1 && awOk && wOk) begin
            done = 1;
            check("bresp", bresp, RESP_OKAY);
         end
         if (!awOk && awready === 1'b1) begin
            awOk = 1;
            awvalid <= 1'b0;
         end
         if (!wOk && wready === 1'b1) begin
            wOk = 1;
            wvalid <= 1'b0;
         end
      end
      if (!done) begin
         errorCnt++;
         stopTest();
      end
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      bit arOk;
      bit done;
      arOk = 0;
      done = 0;
      araddr <= a;
      arvalid <= 1'b1;
      for (int n = 0; n < 50 && !done; n++) begin
         @(posedge core_clk);
         if (rvalid === 1'b1 && arOk) begin
            done = 1;
            d = rdata;
            check("rresp", rresp, RESP_OKAY);
         end
         if (!arOk && arready === 1'b1) begin
            arOk = 1;
            arvalid <= 1'b0;
         end
      end
      if (!done) begin
         errorCnt++;
         stopTest();
      end
   endtask

   function automatic logic expHit(input logic [2:0] code, input logic lvl);
      case (code)
         TRIG_LOW, TRIG_FALL:  return !lvl;
         TRIG_HIGH, TRIG_RISE: return lvl;
         TRIG_BOTH:            return 1'b1;
         default:              return 1'b0;
      endcase
   endfunction

   function automatic logic [1:0] expEdge(input logic [2:0] code, input logic lvl);
      return (code == TRIG_BOTH) ? (lvl ? 2'b01 : 2'b10) : EDGE_NONE;
   endfunction

   function automatic logic [31:0] expCtrl(input logic [31:0] d);
      logic [31:0] r;
      for (int i = 0; i < 4; i++) r[8*i +: 8] = {1'b0, d[8*i+4 +: 3], 3'b000, d[8*i]};
      return r;
   endfunction

   // One source is armed, the line moves to the chosen level, and then it is cleared.
   task automatic trial(input int idx, input logic [2:0] code, input logic lvl);
      logic [31:0] r;
      logic [3:0]  s;
      logic [4:0]  clr;
      int          base;
      s = 4'h1 << idx;
      clr = CLR_RTC + 5'(idx);
      // Level codes start from the inactive level, so arming never sees a live hit.
      if (code == TRIG_LOW) srcLine[idx] <= 1'b1;
      else if (code == TRIG_HIGH) srcLine[idx] <= 1'b0;
      else srcLine[idx] <= ~lvl;
      repeat (3) @(posedge core_clk);
      wr(OFF_MODE_CTRL, {4{1'b0, code, 4'h0}}, s);
      wr(OFF_MODE_CTRL, {4{1'b0, code, 4'h1}}, s);
      wr(OFF_REQ_CLEAR, {27'h0, clr}, 4'h1);
      wr(OFF_INT_STAT, 32'hf, 4'h1);
      base = reqSeen;
      srcLine[idx] <= lvl;
      repeat (5) @(posedge core_clk);
      rd(OFF_INT_STAT, r);
      check("pending", r[idx], expHit(code, lvl));
      check("wake request", reqSeen != base, expHit(code, lvl));
      check("irq", irq, expHit(code, lvl));
      rd(OFF_MODE_CTRL, r);
      check("edge status", r[8*idx+2 +: 2], expEdge(code, lvl));
      if (code == TRIG_BOTH) begin
         srcLine[idx] <= ~lvl;
         repeat (5) @(posedge core_clk);
         rd(OFF_MODE_CTRL, r);
         check("both edges", r[8*idx+2 +: 2], 2'b11);
      end
      wr(OFF_MODE_CTRL, {4{1'b0, code, 4'h0}}, s);
      wr(OFF_REQ_CLEAR, {27'h0, clr}, 4'h1);
      rd(OFF_MODE_CTRL, r);
      check("cleared status", r[8*idx+2 +: 2], EDGE_NONE);
      rd(OFF_INT_STAT, r);
      check("cleared pending", r[idx], 1'b0);
   endtask

   initial begin
      logic [31:0] d;
      logic [31:0] r;
      void'($urandom(32'hd159e2ea));
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      check("reset irq", irq, 1'b0);
      rd(OFF_MODE_CTRL, r);
      check("reset control", r, 32'h2020_2020);
      for (int k = 0; k < 6; k++) begin
         d = $urandom;
         for (int i = 0; i < 4; i++) d[8*i+4 +: 3] = 3'($urandom % 5);
         d[6:4] = TRIG_FALL;
         d[30:28] = TRIG_RISE;
         wr(OFF_MODE_CTRL, d & ~32'h0101_0101, 4'hf);
         wr(OFF_MODE_CTRL, d, 4'hf);
         rd(OFF_MODE_CTRL, r);
         check("control", r, expCtrl(d));
      end
      check("request out of standby", reqSeen, 32'h0);
      wr(OFF_MODE_CTRL, 32'h3040_4020, 4'hf);
      wr(OFF_INT_STAT, 32'hf, 4'h1);
      wr(OFF_INT_MASK, 32'hf, 4'h1);
      standbyActive <= 1'b1;
      d = reqSeen;
      srcLine <= 4'hf;
      repeat (4) @(posedge core_clk);
      srcLine <= 4'h0;
      repeat (4) @(posedge core_clk);
      rd(OFF_INT_STAT, r);
      check("disabled pending", r[3:0], 4'h0);
      check("disabled request", reqSeen, d);
      trial(0, TRIG_FALL, 1'b0);
      trial(0, TRIG_FALL, 1'b1);
      trial(3, TRIG_RISE, 1'b1);
      trial(1, TRIG_BOTH, 1'b0);
      for (int c = 0; c < 8; c++) trial(2, 3'(c), c[0]);
      for (int k = 0; k < 12; k++) begin
         int         idx;
         logic [2:0] code;
         idx = $urandom % 4;
         code = (idx == 0) ? TRIG_FALL : (idx == 3) ? TRIG_RISE : 3'($urandom % 5);
         trial(idx, code, 1'($urandom));
      end
      // A pending bit that is masked must not reach irq, and a bad clear code does nothing.
      srcLine <= 4'hf;
      repeat (3) @(posedge core_clk);
      wr(OFF_MODE_CTRL, 32'h20, 4'h1);
      wr(OFF_MODE_CTRL, 32'h21, 4'h1);
      wr(OFF_INT_MASK, 32'h0, 4'h1);
      srcLine[0] <= 1'b0;
      repeat (5) @(posedge core_clk);
      check("masked irq", irq, 1'b0);
      wr(OFF_REQ_CLEAR, {27'h0, CLR_PROHIB}, 4'h1);
      rd(OFF_INT_STAT, r);
      check("prohibited clear", r[0], 1'b1);
      wr(OFF_INT_MASK, 32'hf, 4'h1);
      repeat (2) @(posedge core_clk);
      check("unmasked irq", irq, 1'b1);
      wr(OFF_INT_STAT, 32'h1, 4'h1);
      repeat (2) @(posedge core_clk);
      check("irq after clear", irq, 1'b0);
      stopTest();
   end
endmodule
